// ---- rtl/bcg_pkg.sv ----
// constants and helper functions shared by the base clock generation unit
package bcg_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NUM_SRC  = 12;
  localparam int SEL_W    = 4;
  localparam int NUM_BASE = 9;
  localparam int NUM_FDIV = 7;
  localparam int NUM_GEN  = 17;
  localparam int IDX_W    = 5;
  localparam int CFG_W    = 8;

  // ****************************************************************
  // source codes, one encoding for every selector
  // ****************************************************************
  localparam logic [3:0] SRC_RING      = 4'h0;
  localparam logic [3:0] SRC_XTAL      = 4'h1;
  localparam logic [3:0] SRC_PLL0      = 4'h2;
  localparam logic [3:0] SRC_PLL120    = 4'h3;
  localparam logic [3:0] SRC_PLL240    = 4'h4;
  localparam logic [3:0] SRC_FDIV0     = 4'h5;
  localparam logic [3:0] SRC_FDIV_LAST = 4'hb;

  // ****************************************************************
  // generator indices: base clocks 0..8, dividers, pll reference
  // ****************************************************************
  localparam logic [4:0] GEN_SAFE   = 5'h00;
  localparam logic [4:0] GEN_SYS    = 5'h01;
  localparam logic [4:0] GEN_CTRL   = 5'h02;
  localparam logic [4:0] GEN_NET    = 5'h03;
  localparam logic [4:0] GEN_MIX    = 5'h04;
  localparam logic [4:0] GEN_UART   = 5'h05;
  localparam logic [4:0] GEN_SPI    = 5'h06;
  localparam logic [4:0] GEN_TMR    = 5'h07;
  localparam logic [4:0] GEN_ADC    = 5'h08;
  localparam logic [4:0] GEN_FDIV0  = 5'h09;
  localparam logic [4:0] GEN_PLL_IN = 5'h10;

  // ****************************************************************
  // reset values and timing
  // ****************************************************************
  localparam logic [3:0] SEL_RST       = SRC_RING;
  localparam logic [7:0] CFG_RST       = 8'h00;
  localparam int         DET_LIMIT     = 32;
  localparam int         STUCK_LIMIT   = 32;
  localparam int         CLK_PERIOD_NS = 20;
  localparam int         SYNC_HOLD_CYC = 2;
  localparam int         PLL_HOLD_NS   = 2000;
  localparam int         PLL_HOLD_CYC  =
    (PLL_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  function automatic logic is_pll(input logic [3:0] code);
    return (code >= SRC_PLL0) && (code <= SRC_PLL240);
  endfunction

  // static legality of a source for a generator
  function automatic logic sel_legal(input logic [4:0] idx,
                                     input logic [3:0] code);
    if (code > SRC_FDIV_LAST) return 1'b0;
    if (idx == GEN_SAFE || idx == GEN_CTRL) return code == SRC_RING;
    if (idx <= GEN_ADC) return 1'b1;
    if (idx < GEN_PLL_IN) return code < SRC_FDIV0;
    if (idx == GEN_PLL_IN) return code == SRC_XTAL || code == SRC_RING;
    return 1'b0;
  endfunction

endpackage

// ---- rtl/bcg_act_det.sv ----
// activity detector for one clock source
`timescale 1ns/1ps
module bcg_act_det (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic src_in,
  output logic      src_lvl,
  output logic      active,
  output logic      up_evt,
  output logic      down_evt
);

  logic       s1_r, s2_r, s3_r;
  logic [5:0] cnt_r, cnt_nxt;
  logic       act_r, act_nxt;
  logic       up_r, up_nxt;
  logic       dn_r, dn_nxt;
  logic       edge_seen;

  assign edge_seen = s2_r & ~s3_r;

  always_comb begin
    cnt_nxt = cnt_r;
    act_nxt = act_r;
    if (edge_seen) begin
      cnt_nxt = 6'h00;
      act_nxt = 1'b1;
    end else if (cnt_r == 6'(bcg_pkg::DET_LIMIT - 1)) begin
      act_nxt = 1'b0;
    end else begin
      cnt_nxt = cnt_r + 6'h01;
    end
    up_nxt = act_nxt & ~act_r;
    dn_nxt = ~act_nxt & act_r;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // high reset level: a pin stuck high gives no false edge
      s1_r  <= 1'b1;
      s2_r  <= 1'b1;
      s3_r  <= 1'b1;
      cnt_r <= 6'h00;
      act_r <= 1'b0;
      up_r  <= 1'b0;
      dn_r  <= 1'b0;
    end else begin
      s1_r  <= src_in;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      cnt_r <= cnt_nxt;
      act_r <= act_nxt;
      up_r  <= up_nxt;
      dn_r  <= dn_nxt;
    end
  end

  assign src_lvl  = s3_r;
  assign active   = act_r;
  assign up_evt   = up_r;
  assign down_evt = dn_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  quiet_goes_inactive_a: assert property (
    (!edge_seen)[*8] ##1 (cnt_r == 6'(bcg_pkg::DET_LIMIT - 1)
      && !edge_seen) |=> !act_r)
    else $error("source not declared inactive after quiet count");
  edge_goes_active_a: assert property (
    edge_seen |=> act_r && up_r == !$past(act_r))
    else $error("edge did not mark source active");

endmodule // bcg_act_det

// ---- rtl/bcg_gf_sw.sv ----
// glitch-free source switch for one generator
`timescale 1ns/1ps
module bcg_gf_sw #(
  parameter int PLL_HOLD = bcg_pkg::PLL_HOLD_CYC
) (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic [bcg_pkg::NUM_SRC-1:0] src_lvl,
  input  wire logic [3:0]                  sel_in,
  input  wire logic                        pll_lock,
  output logic                             clk_out,
  output logic                             busy
);

  typedef enum logic [1:0] {SW_RUN, SW_WAIT, SW_HOLD} bcg_sw_e;

  bcg_sw_e    st_r, st_nxt;
  logic [3:0] cur_r, cur_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic       pll_r, pll_nxt;
  logic       out_r, out_nxt;
  logic [7:0] lim;

  assign lim = pll_r ? 8'(PLL_HOLD) : 8'(bcg_pkg::SYNC_HOLD_CYC);

  always_comb begin
    st_nxt  = st_r;
    cur_nxt = cur_r;
    cnt_nxt = cnt_r;
    pll_nxt = pll_r;
    out_nxt = 1'b0;
    unique case (st_r)
      SW_RUN: begin
        // a stopped source is still passed on
        out_nxt = src_lvl[cur_r] & ~(bcg_pkg::is_pll(cur_r) & ~pll_lock);
        if (sel_in != cur_r) begin
          st_nxt  = SW_WAIT;
          cnt_nxt = 8'h00;
          out_nxt = out_r & src_lvl[cur_r];
        end
      end
      SW_WAIT: begin
        // output may only fall here, never rise
        out_nxt = out_r & src_lvl[cur_r];
        cnt_nxt = cnt_r + 8'h01;
        if (!out_nxt || cnt_r == 8'(bcg_pkg::STUCK_LIMIT - 1)) begin
          out_nxt = 1'b0;
          st_nxt  = SW_HOLD;
          cnt_nxt = 8'h00;
          pll_nxt = bcg_pkg::is_pll(cur_r) | bcg_pkg::is_pll(sel_in);
        end
      end
      SW_HOLD: begin
        if (cnt_r < lim) cnt_nxt = cnt_r + 8'h01;
        if (cnt_r >= lim && (!bcg_pkg::is_pll(sel_in) || pll_lock)) begin
          cur_nxt = sel_in;
          st_nxt  = SW_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r  <= SW_RUN;
      cur_r <= bcg_pkg::SEL_RST;
      cnt_r <= 8'h00;
      pll_r <= 1'b0;
      out_r <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      cur_r <= cur_nxt;
      cnt_r <= cnt_nxt;
      pll_r <= pll_nxt;
      out_r <= out_nxt;
    end
  end

  assign clk_out = out_r;
  assign busy    = st_r != SW_RUN;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_hold_entry;
    st_r == SW_WAIT ##1 st_r == SW_HOLD;
  endsequence

  hold_low_a: assert property (
    s_hold_entry |-> !out_r ##1 !out_r)
    else $error("output not low while switching");
  stuck_bound_a: assert property (
    st_r == SW_RUN ##1 st_r == SW_WAIT |-> ##[1:33] st_r == SW_HOLD)
    else $error("stuck high source not forced low in time");
  no_rise_wait_a: assert property (
    st_r == SW_WAIT && !out_r |=> !out_r)
    else $error("output rose during switch");
  pll_hold_a: assert property (
    st_r == SW_HOLD && pll_r && !pll_lock && bcg_pkg::is_pll(sel_in)
      |=> st_r == SW_HOLD)
    else $error("pll switch left hold without lock");

endmodule // bcg_gf_sw

// ---- rtl/bcg_base_clk_gen.sv ----
// base clock generation unit: selectors, detectors and switches
`timescale 1ns/1ps
module bcg_base_clk_gen #(
  parameter int PLL_HOLD = bcg_pkg::PLL_HOLD_CYC
) (
  input  wire logic                                  clk,
  input  wire logic                                  sys_rst,
  input  wire logic                                  ring_osc_in,
  input  wire logic                                  xtal_in,
  input  wire logic [2:0]                            pll_clk_in,
  input  wire logic                                  pll_lock_in,
  input  wire logic [bcg_pkg::NUM_FDIV-1:0]          fdiv_clk_in,
  input  wire logic                                  triple_phase_enable,
  input  wire logic                                  wr_en,
  input  wire logic [bcg_pkg::IDX_W-1:0]             wr_idx,
  input  wire logic [bcg_pkg::SEL_W-1:0]             wr_sel,
  input  wire logic [bcg_pkg::CFG_W-1:0]             wr_cfg,
  output logic [bcg_pkg::NUM_GEN*bcg_pkg::SEL_W-1:0] gen_sel,
  output logic [bcg_pkg::NUM_GEN*bcg_pkg::CFG_W-1:0] gen_cfg,
  output logic                                       wr_blocked,
  output logic [bcg_pkg::NUM_SRC-1:0]                activity_status,
  output logic [bcg_pkg::NUM_SRC-1:0]                clk_up_evt,
  output logic [bcg_pkg::NUM_SRC-1:0]                clk_down_evt,
  output logic [bcg_pkg::NUM_BASE-1:0]               base_clk,
  output logic [bcg_pkg::NUM_FDIV-1:0]               fdiv_in_clk,
  output logic [bcg_pkg::NUM_BASE+bcg_pkg::NUM_FDIV-1:0] switch_busy,
  output logic                                       pll_phase_sync
);

  localparam int NSW = bcg_pkg::NUM_BASE + bcg_pkg::NUM_FDIV;

  // ****************************************************************
  // source vector, bit position equals source code
  // ****************************************************************
  logic [bcg_pkg::NUM_SRC-1:0] src_raw;
  logic [bcg_pkg::NUM_SRC-1:0] src_lvl;
  logic [bcg_pkg::NUM_SRC-1:0] src_act;

  // ring oscillator has no power-down control at all
  assign src_raw = {fdiv_clk_in, pll_clk_in, xtal_in, ring_osc_in};

  // ****************************************************************
  // pll lock synchroniser and phase alignment request
  // ****************************************************************
  logic lk1_r, lk2_r;
  logic psync_r, psync_nxt;

  always_comb begin
    // aligning before lock would fix an unknown phase relation
    psync_nxt = triple_phase_enable & lk2_r;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lk1_r   <= 1'b0;
      lk2_r   <= 1'b0;
      psync_r <= 1'b0;
    end else begin
      lk1_r   <= pll_lock_in;
      lk2_r   <= lk1_r;
      psync_r <= psync_nxt;
    end
  end

  assign pll_phase_sync = psync_r;

  // ****************************************************************
  // activity detectors
  // ****************************************************************
  genvar gs;
  generate
    for (gs = 0; gs < bcg_pkg::NUM_SRC; gs++) begin : g_det
      bcg_act_det u_det (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .src_in   (src_raw[gs]),
        .src_lvl  (src_lvl[gs]),
        .active   (src_act[gs]),
        .up_evt   (clk_up_evt[gs]),
        .down_evt (clk_down_evt[gs])
      );
    end
  endgenerate

  assign activity_status = src_act;

  // ****************************************************************
  // selector and field storage
  // ****************************************************************
  logic [3:0] sel_r   [bcg_pkg::NUM_GEN];
  logic [3:0] sel_nxt [bcg_pkg::NUM_GEN];
  logic [7:0] cfg_r   [bcg_pkg::NUM_GEN];
  logic [7:0] cfg_nxt [bcg_pkg::NUM_GEN];
  logic       blk_r, blk_nxt;
  logic       wr_hit;
  logic       wr_ok;

  assign wr_hit = wr_en && (wr_idx < 5'(bcg_pkg::NUM_GEN));

  // legal for the generator and currently seen running
  assign wr_ok = bcg_pkg::sel_legal(wr_idx, wr_sel)
                 && src_act[wr_sel];

  always_comb begin
    for (int i = 0; i < bcg_pkg::NUM_GEN; i++) begin
      sel_nxt[i] = sel_r[i];
      cfg_nxt[i] = cfg_r[i];
    end
    blk_nxt = 1'b0;
    if (wr_hit) begin
      cfg_nxt[wr_idx] = wr_cfg;
      if (wr_ok) begin
        sel_nxt[wr_idx] = wr_sel;
      end else begin
        blk_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < bcg_pkg::NUM_GEN; i++) begin
        sel_r[i] <= bcg_pkg::SEL_RST;
        cfg_r[i] <= bcg_pkg::CFG_RST;
      end
      blk_r <= 1'b0;
    end else begin
      for (int i = 0; i < bcg_pkg::NUM_GEN; i++) begin
        sel_r[i] <= sel_nxt[i];
        cfg_r[i] <= cfg_nxt[i];
      end
      blk_r <= blk_nxt;
    end
  end

  assign wr_blocked = blk_r;

  genvar gg;
  generate
    for (gg = 0; gg < bcg_pkg::NUM_GEN; gg++) begin : g_flat
      assign gen_sel[gg*bcg_pkg::SEL_W +: bcg_pkg::SEL_W] = sel_r[gg];
      assign gen_cfg[gg*bcg_pkg::CFG_W +: bcg_pkg::CFG_W] = cfg_r[gg];
    end
  endgenerate

  // ****************************************************************
  // glitch-free switches: base clocks then divider inputs
  // ****************************************************************
  logic [NSW-1:0] sw_out;

  genvar gw;
  generate
    for (gw = 0; gw < NSW; gw++) begin : g_sw
      bcg_gf_sw #(
        .PLL_HOLD (PLL_HOLD)
      ) u_sw (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .src_lvl  (src_lvl),
        .sel_in   (sel_r[gw]),
        .pll_lock (lk2_r),
        .clk_out  (sw_out[gw]),
        .busy     (switch_busy[gw])
      );
    end
  endgenerate

  // whole unit lives on the always-on clock; no bus side exists here
  assign base_clk    = sw_out[bcg_pkg::NUM_BASE-1:0];
  assign fdiv_in_clk = sw_out[NSW-1:bcg_pkg::NUM_BASE];

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [4:0] last_idx_r;
  logic [3:0] last_sel_r;
  logic [7:0] last_cfg_r;
  logic [3:0] old_sel_r;

  always_ff @(posedge clk) begin
    last_idx_r <= wr_idx;
    last_sel_r <= wr_sel;
    last_cfg_r <= wr_cfg;
    old_sel_r  <= sel_r[wr_idx];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  good_write_a: assert property (
    wr_hit && wr_ok |=> sel_r[last_idx_r] == last_sel_r && !wr_blocked)
    else $error("legal select not stored");
  blocked_keep_a: assert property (
    wr_hit && !wr_ok |=> sel_r[last_idx_r] == old_sel_r && wr_blocked
      && cfg_r[last_idx_r] == last_cfg_r)
    else $error("refused select changed or fields not written");
  safe_ring_a: assert property (
    sel_r[bcg_pkg::GEN_SAFE] == bcg_pkg::SRC_RING
      && sel_r[bcg_pkg::GEN_CTRL] == bcg_pkg::SRC_RING)
    else $error("safe or control clock left the ring oscillator");
  dead_refused_a: assert property (
    wr_hit && !src_act[wr_sel] |=> wr_blocked)
    else $error("select of inactive source accepted");
  fdiv_no_fdiv_a: assert property (
    wr_hit && wr_idx >= bcg_pkg::GEN_FDIV0 && wr_idx < bcg_pkg::GEN_PLL_IN
      && wr_sel >= bcg_pkg::SRC_FDIV0 |=> wr_blocked)
    else $error("divider allowed to take a divider");
  pll_ref_a: assert property (
    wr_hit && wr_idx == bcg_pkg::GEN_PLL_IN && wr_sel >= bcg_pkg::SRC_PLL0
      |=> wr_blocked)
    else $error("pll reference allowed from pll or divider");
  rst_ring_a: assert property (
    @(posedge clk) disable iff (1'b0)
    $fell(sys_rst) |-> sel_r[bcg_pkg::GEN_SYS] == bcg_pkg::SRC_RING
      && sel_r[bcg_pkg::GEN_PLL_IN] == bcg_pkg::SRC_RING && !wr_blocked)
    else $error("selector not on ring oscillator after reset");
  absent_rst_a: assert property (
    @(posedge clk) disable iff (1'b0)
    $fell(sys_rst) |-> activity_status == '0 ##1 activity_status == '0)
    else $error("source active too soon after reset");
  phase_sync_a: assert property (
    !lk2_r |=> !pll_phase_sync)
    else $error("phases aligned before pll lock");

endmodule // bcg_base_clk_gen

// ---- test/test_bcg_base_clk_gen.sv ----
// self-checking bench for the base clock generation unit
`timescale 1ns/1ps
module test_bcg_base_clk_gen;
  // short pll hold keeps the run brief
  localparam int HOLD = 4;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic         clk                 = 1'b0;
  logic         sys_rst             = 1'b1;
  logic         ring_osc_in         = 1'b0;
  logic         xtal_in             = 1'b0;
  logic [2:0]   pll_clk_in          = 3'h0;
  logic         pll_lock_in         = 1'b0;
  logic [6:0]   fdiv_clk_in         = 7'h00;
  logic         triple_phase_enable = 1'b0;
  logic         wr_en               = 1'b0;
  logic [4:0]   wr_idx              = 5'h00;
  logic [3:0]   wr_sel              = 4'h0;
  logic [7:0]   wr_cfg              = 8'h00;
  logic [67:0]  gen_sel;
  logic [135:0] gen_cfg;
  logic         wr_blocked;
  logic [11:0]  activity_status;
  logic [11:0]  clk_up_evt;
  logic [11:0]  clk_down_evt;
  logic [8:0]   base_clk;
  logic [6:0]   fdiv_in_clk;
  logic [15:0]  switch_busy;
  logic         pll_phase_sync;
  logic         xtal_run            = 1'b0;
  logic         pll_run             = 1'b0;
  logic [1:0]   tick                = 2'h0;
  logic [67:0]  exp_sel             = '0;
  logic [135:0] exp_cfg             = '0;
  int           up_cnt              = 0;
  int           down_cnt            = 0;
  int           cyc                 = 0;
  int           miscompares         = 0;
  int           num_checks          = 0;

  bcg_base_clk_gen #(.PLL_HOLD(HOLD)) uut (
    .clk                 (clk),
    .sys_rst             (sys_rst),
    .ring_osc_in         (ring_osc_in),
    .xtal_in             (xtal_in),
    .pll_clk_in          (pll_clk_in),
    .pll_lock_in         (pll_lock_in),
    .fdiv_clk_in         (fdiv_clk_in),
    .triple_phase_enable (triple_phase_enable),
    .wr_en               (wr_en),
    .wr_idx              (wr_idx),
    .wr_sel              (wr_sel),
    .wr_cfg              (wr_cfg),
    .gen_sel             (gen_sel),
    .gen_cfg             (gen_cfg),
    .wr_blocked          (wr_blocked),
    .activity_status     (activity_status),
    .clk_up_evt          (clk_up_evt),
    .clk_down_evt        (clk_down_evt),
    .base_clk            (base_clk),
    .fdiv_in_clk         (fdiv_in_clk),
    .switch_busy         (switch_busy),
    .pll_phase_sync      (pll_phase_sync)
  );

  always #10 clk = ~clk;

  // ****************************************************************
  // source clocks, slower than clk so the sampled detector sees them
  // ****************************************************************
  always @(posedge clk) begin
    tick <= tick + 2'h1;
    if (tick[0]) begin
      ring_osc_in <= ~ring_osc_in;
      pll_clk_in  <= pll_run ? ~pll_clk_in : 3'h0;
    end
    // a stopped crystal sticks high to exercise the forced-low path
    xtal_in     <= xtal_run ? ~xtal_in : 1'b1;
    pll_lock_in <= pll_run;
  end

  // ****************************************************************
  // event counting and hang guard
  // ****************************************************************
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!sys_rst && clk_up_evt[1] === 1'b1) up_cnt <= up_cnt + 1;
    if (!sys_rst && clk_down_evt[1] === 1'b1) down_cnt <= down_cnt + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      print_verdict();
    end
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input logic [135:0] got, input logic [135:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] idx, input logic [3:0] sel,
                    input logic [7:0] cfg, input logic blk);
    @(posedge clk);
    wr_en  <= 1'b1;
    wr_idx <= idx;
    wr_sel <= sel;
    wr_cfg <= cfg;
    @(posedge clk);
    wr_en <= 1'b0;
    @(negedge clk);
    if (idx < 5'h11) begin
      if (!blk) exp_sel[int'(idx)*4 +: 4] = sel;
      exp_cfg[int'(idx)*8 +: 8] = cfg;
    end
    chk(wr_blocked, blk);
    chk(gen_sel, exp_sel);
    chk(gen_cfg, exp_cfg);
  endtask

  task automatic wait_act(input int b, input logic v, output int n);
    n = 0;
    while (activity_status[b] !== v && n < 60) begin
      @(negedge clk);
      n = n + 1;
    end
  endtask

  // busy length of one switch and how often its output rose
  task automatic wait_sw(input int g, output int n, output int hi);
    logic prev;
    n = 0;
    hi = 0;
    // busy rises one edge after the stored select changes
    @(negedge clk);
    prev = base_clk[g];
    while (switch_busy[g] !== 1'b0 && n < 200) begin
      if (base_clk[g] === 1'b1 && prev !== 1'b1) hi = hi + 1;
      prev = base_clk[g];
      @(negedge clk);
      n = n + 1;
    end
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    chk(gen_sel, 68'h0);
    chk(gen_cfg, 136'h0);
    chk(activity_status, 12'h000);
    $display("test reset done");
  endtask

  task automatic t_detect;
    int n;
    xtal_run <= 1'b1;
    wait_act(1, 1'b1, n);
    chk(n < 12, 1'b1);
    wait_act(0, 1'b1, n);
    chk(activity_status[0], 1'b1);
    chk(activity_status[2], 1'b0);
    @(negedge clk);
    chk(up_cnt, 1);
    $display("test detect done");
  endtask

  task automatic t_select;
    int n;
    int hi;
    wr(5'h01, bcg_pkg::SRC_XTAL, 8'h11, 1'b0);
    wr(5'h05, bcg_pkg::SRC_XTAL, 8'h15, 1'b0);
    wait_sw(5, n, hi);
    chk(n < 12, 1'b1);
    chk(hi, 0);
    repeat (6) @(negedge clk);
    chk(base_clk[5], base_clk[1]);
    wr(5'h00, bcg_pkg::SRC_XTAL, 8'h20, 1'b1);
    wr(5'h02, bcg_pkg::SRC_XTAL, 8'h22, 1'b1);
    wr(5'h10, bcg_pkg::SRC_XTAL, 8'h30, 1'b0);
    wr(5'h10, bcg_pkg::SRC_FDIV0, 8'h31, 1'b1);
    wr(5'h10, bcg_pkg::SRC_PLL0, 8'h32, 1'b1);
    wr(5'h09, bcg_pkg::SRC_XTAL, 8'h39, 1'b0);
    wr(5'h0a, bcg_pkg::SRC_FDIV0, 8'h3a, 1'b1);
    wr(5'h03, bcg_pkg::SRC_PLL0, 8'h43, 1'b1);
    wr(5'h06, 4'hc, 8'h46, 1'b1);
    wr(5'h14, bcg_pkg::SRC_XTAL, 8'h50, 1'b0);
    $display("test select done");
  endtask

  task automatic t_pll;
    int n;
    int hi;
    pll_run             <= 1'b1;
    triple_phase_enable <= 1'b1;
    wait_act(2, 1'b1, n);
    chk(activity_status[4:2], 3'h7);
    wr(5'h07, bcg_pkg::SRC_PLL0, 8'h67, 1'b0);
    wait_sw(7, n, hi);
    chk(n >= HOLD, 1'b1);
    chk(hi, 0);
    wr(5'h04, bcg_pkg::SRC_PLL120, 8'h64, 1'b0);
    wr(5'h0b, bcg_pkg::SRC_PLL240, 8'h6b, 1'b0);
    chk(pll_phase_sync, 1'b1);
    $display("test pll done");
  endtask

  task automatic t_stop;
    int n;
    int hi;
    xtal_run <= 1'b0;
    repeat (20) @(negedge clk);
    chk(activity_status[1], 1'b1);
    wait_act(1, 1'b0, n);
    chk(n < 20, 1'b1);
    @(negedge clk);
    chk(down_cnt, 1);
    wr(5'h08, bcg_pkg::SRC_XTAL, 8'h78, 1'b1);
    // crystal is stuck high, so the switch must time out and force low
    wr(5'h01, bcg_pkg::SRC_RING, 8'h71, 1'b0);
    wait_sw(1, n, hi);
    chk(n < 45, 1'b1);
    $display("test stop done");
  endtask

  // ****************************************************************
  // closing
  // ****************************************************************
  task automatic print_verdict;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_detect();
    t_select();
    t_pll();
    t_stop();
    print_verdict();
  end
endmodule // test_bcg_base_clk_gen
